// File: rtl/baud_gen.sv
// Function
// - After reset the timer counts in 8-bit width until software widens it.
// - Wide divider select set makes the timer use its full 16-bit width.
// - Timer runs continuously, period set by the low divisor byte, plus the high byte when wide.
// - One timer serves both asynchronous and synchronous operation.
// - Async multiplier is chosen jointly by high-speed and wide select bits.
// - Synchronous operation ignores the high-speed select bit.
// - Any divisor byte write clears the timer at once.
// - Divisor n is the high byte concatenated above the low byte when wide, else the low byte alone.
// - Async, narrow, high-speed 0: rate is clock over 64 times (n+1).
// - Async, narrow, high-speed 1: rate is clock over 16 times (n+1).
// - Synchronous, either width: rate is clock over 4 times (n+1).
// - Overrun flag rises when a third character lands with two unread.
`timescale 1ns/100ps
module baud_gen
(
  input wire logic aclk, // System clock, 25 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic char_done, // Receiver finished a character, pulse
  input wire logic data_read, // Receive data register read, pulse
  input wire logic receive_idle_flag, // Receiver idle, level
  output logic timer_tick, // Divider timer expiry, pulse
  output logic baud_tick, // One pulse per bit period
  output logic overrun_error_flag, // Receive overrun, level
  output logic irq // Interrupt, high while enabled status set
);

  logic aw_held, w_held, do_write, wr_lane, div_wr, wr_ok;
  logic wr_ctrl, wr_div_low, wr_div_high, wr_irq_clear, wr_irq_enable;
  logic rd_take, rd_ok;
  logic [7:0] aw_addr;
  logic [3:0] w_strb;
  logic [31:0] w_data, rd_value;
  logic [baud_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [7:0] div_low, div_high;
  logic wide, high_speed, sync_mode, rx_en;
  logic [15:0] timer, reload;
  logic brg_zero;
  logic [5:0] post, post_last;
  logic [1:0] rx_count;
  logic char_take, overrun_set;
  logic [baud_pkg::IRQ_WIDTH-1:0] irq_status, irq_enable;
  logic [baud_pkg::IRQ_WIDTH-1:0] irq_events, next_irq_status;

  // Bus slave: address and data are caught independently, either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // Every field sits in byte lane 0, so only that strobe matters
  assign wr_lane = do_write && w_strb[0];
  assign wr_ctrl = wr_lane && aw_addr == baud_pkg::ADDR_CTRL;
  assign wr_div_low = wr_lane && aw_addr == baud_pkg::ADDR_DIV_LOW;
  assign wr_div_high = wr_lane && aw_addr == baud_pkg::ADDR_DIV_HIGH;
  assign wr_irq_clear = wr_lane && aw_addr == baud_pkg::ADDR_IRQ_CLEAR;
  assign wr_irq_enable = wr_lane && aw_addr == baud_pkg::ADDR_IRQ_ENABLE;
  assign div_wr = wr_div_low || wr_div_high;
  assign wr_ok = aw_addr == baud_pkg::ADDR_CTRL
    || aw_addr == baud_pkg::ADDR_DIV_LOW
    || aw_addr == baud_pkg::ADDR_DIV_HIGH
    || aw_addr == baud_pkg::ADDR_IRQ_CLEAR
    || aw_addr == baud_pkg::ADDR_IRQ_ENABLE;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= baud_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? baud_pkg::RESP_OKAY : baud_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_value = 32'h00000000;
    case (s_axi_araddr)
      baud_pkg::ADDR_CTRL: rd_value[baud_pkg::CTRL_WIDTH-1:0] = ctrl;
      baud_pkg::ADDR_DIV_LOW: rd_value[7:0] = div_low;
      baud_pkg::ADDR_DIV_HIGH: rd_value[7:0] = div_high;
      baud_pkg::ADDR_STATUS:
      begin
        rd_value[baud_pkg::STAT_IDLE_BIT] = receive_idle_flag;
        rd_value[baud_pkg::STAT_OVR_BIT] = overrun_error_flag;
        rd_value[baud_pkg::STAT_COUNT_LSB+:2] = rx_count;
      end
      baud_pkg::ADDR_TIMER: rd_value[15:0] = timer;
      baud_pkg::ADDR_IRQ_STATUS: rd_value = 32'(irq_status);
      baud_pkg::ADDR_IRQ_CLEAR: rd_value = 32'h00000000;
      baud_pkg::ADDR_IRQ_ENABLE: rd_value = 32'(irq_enable);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= baud_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? baud_pkg::RESP_OKAY : baud_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= baud_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= w_data[baud_pkg::CTRL_WIDTH-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_low <= baud_pkg::DIV_RESET;
      div_high <= baud_pkg::DIV_RESET;
    end
    else
    begin
      if (wr_div_low)
        div_low <= w_data[7:0];
      if (wr_div_high)
        div_high <= w_data[7:0];
    end
  end

  assign wide = ctrl[baud_pkg::CTRL_WIDE_BIT];
  assign high_speed = ctrl[baud_pkg::CTRL_HS_BIT];
  assign sync_mode = ctrl[baud_pkg::CTRL_SYNC_BIT];
  assign rx_en = ctrl[baud_pkg::CTRL_RXEN_BIT];

  // Divider timer: counts n down to zero, n+1 clocks a period
  assign reload = wide ? {div_high, div_low} : {8'h00, div_low};
  assign brg_zero = timer == 16'h0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer <= 16'h0000;
    else if (div_wr)
      timer <= 16'h0000;
    else if (brg_zero)
      timer <= reload;
    else
      timer <= timer - 16'h0001;
  end

  // Multiplier stage after the timer; sync ignores high-speed select
  always_comb
  begin
    if (sync_mode)
      post_last = baud_pkg::POST_LAST_4;
    else if (!wide)
      post_last = high_speed ? baud_pkg::POST_LAST_16
        : baud_pkg::POST_LAST_64;
    else
      post_last = high_speed ? baud_pkg::POST_LAST_4
        : baud_pkg::POST_LAST_16;
  end

  // Wraps on >= so a mode change to a smaller multiplier cannot stall
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      post <= 6'h00;
    else if (div_wr)
      post <= 6'h00;
    else if (brg_zero)
      post <= (post >= post_last) ? 6'h00 : post + 6'h01;
  end

  always_ff @(posedge aclk)
  begin
    timer_tick <= aresetn && brg_zero && !div_wr;
    baud_tick <= aresetn && brg_zero && !div_wr && post >= post_last;
  end

  // Two-character receive holding count and overrun
  assign char_take = char_done && rx_en && !overrun_error_flag
    && rx_count != baud_pkg::RX_DEPTH;
  assign overrun_set = char_done && rx_en && !overrun_error_flag
    && rx_count == baud_pkg::RX_DEPTH;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_count <= 2'h0;
    else if (char_take && !(data_read && rx_count != 2'h0))
      rx_count <= rx_count + 2'h1;
    else if (!char_take && data_read && rx_count != 2'h0)
      rx_count <= rx_count - 2'h1;
  end

  // Cleared only by turning reception off; overrun_set needs rx_en, so no set occurs then
  always_ff @(posedge aclk)
    overrun_error_flag <= aresetn
      && (overrun_set || (overrun_error_flag && rx_en));

  // Interrupt status: sticky, write-one-to-clear, set wins
  always_comb
  begin
    irq_events = '0;
    irq_events[baud_pkg::IRQ_OVR_BIT] = overrun_set;
    irq_events[baud_pkg::IRQ_CHAR_BIT] = char_take;
    next_irq_status = irq_status;
    if (wr_irq_clear)
      next_irq_status = irq_status
        & ~w_data[baud_pkg::IRQ_WIDTH-1:0];
    next_irq_status = next_irq_status | irq_events;
  end

  always_ff @(posedge aclk)
    irq_status <= aresetn ? next_irq_status : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_enable <= baud_pkg::IRQ_EN_RESET;
    else if (wr_irq_enable)
      irq_enable <= w_data[baud_pkg::IRQ_WIDTH-1:0];
  end

  assign irq = |(irq_status & irq_enable);

  // Checking helpers: cycles between bit ticks under steady settings
  logic [31:0] gap, n_plus;
  logic [1:0] seen;
  assign n_plus = {16'h0000, reload} + 32'h00000001;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap <= 32'h00000001;
      seen <= 2'h0;
    end
    else
    begin
      gap <= baud_tick ? 32'h00000001 : gap + 32'h00000001;
      if (wr_ctrl || div_wr)
        seen <= 2'h0;
      else if (baud_tick && seen != 2'h2)
        seen <= seen + 2'h1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_width_narrow: assert property (
    brg_zero && !div_wr && !wide |=> timer == {8'h00, div_low})
    else $error("narrow reload not low byte");
  a_width_wide: assert property (
    brg_zero && !div_wr && wide |=> timer == {div_high, div_low})
    else $error("wide reload not high:low");
  a_timer_run: assert property (
    !brg_zero && !div_wr |=> timer == $past(timer) - 16'h0001)
    else $error("timer did not count down");
  a_div_clear: assert property (
    div_wr |=> timer == 16'h0000 && post == 6'h00 ##1 timer_tick)
    else $error("divisor write did not restart timer");
  a_rate_slow: assert property (
    baud_tick && seen == 2'h2 && !sync_mode && !wide && !high_speed
    |-> gap == 32'h00000040 * n_plus)
    else $error("async narrow slow rate wrong");
  a_rate_fast: assert property (
    baud_tick && seen == 2'h2 && !sync_mode && !wide && high_speed
    |-> gap == 32'h00000010 * n_plus)
    else $error("async narrow fast rate wrong");
  a_rate_sync: assert property (
    baud_tick && seen == 2'h2 && sync_mode
    |-> gap == 32'h00000004 * n_plus)
    else $error("sync rate wrong");
  a_rate_wide: assert property (
    baud_tick && seen == 2'h2 && !sync_mode && wide
    |-> gap == (high_speed ? 32'h00000004 : 32'h00000010) * n_plus)
    else $error("async wide rate wrong");
  a_overrun_set: assert property (
    char_done && rx_en && rx_count == baud_pkg::RX_DEPTH
    |=> overrun_error_flag)
    else $error("overrun not flagged on third character");
  a_overrun_hold: assert property (
    overrun_error_flag && rx_en && !wr_ctrl |=> overrun_error_flag [*2])
    else $error("overrun cleared while reception on");

  c_sync_rate: cover property (baud_tick && seen == 2'h2 && sync_mode);
  c_wide_rate: cover property (baud_tick && seen == 2'h2 && wide);
  c_overrun: cover property ($rose(overrun_error_flag));
  c_div_restart: cover property (div_wr ##1 brg_zero ##1 timer_tick);

endmodule

// File: rtl/baud_pkg.sv
package baud_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV_LOW = 8'h04;
  localparam logic [7:0] ADDR_DIV_HIGH = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_TIMER = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;

  // Control register fields
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_HS_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_RXEN_BIT = 3;
  localparam int CTRL_WIDTH = 4;

  // Status register fields
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_COUNT_LSB = 2;

  // Interrupt bits
  localparam int IRQ_OVR_BIT = 0;
  localparam int IRQ_CHAR_BIT = 1;
  localparam int IRQ_WIDTH = 2;

  // Reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [IRQ_WIDTH-1:0] IRQ_EN_RESET = 2'h0;

  // Last state of the post divider: multipliers 64, 16 and 4
  localparam logic [5:0] POST_LAST_64 = 6'h3f;
  localparam logic [5:0] POST_LAST_16 = 6'h0f;
  localparam logic [5:0] POST_LAST_4 = 6'h03;

  // Receive holding depth in characters
  localparam logic [1:0] RX_DEPTH = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: tb/serial_partner.sv
`timescale 1ns/100ps
module serial_partner
(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Reset, active low
  input wire logic [3:0] n_chars, // Characters to send, taken with go
  input wire logic go, // Start a burst
  input wire logic pop, // Software read of the receive register
  output logic char_done, // Character fully received
  output logic data_read, // Read strobe to the block
  output logic receive_idle_flag // Line idle
);
  logic [3:0] left;
  logic [2:0] gap;

  // Spaced characters, so each is its own pulse as on a real line
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left <= 4'h0;
      gap <= 3'h0;
      char_done <= 1'b0;
    end
    else
    begin
      gap <= gap + 3'h1;
      char_done <= (left != 4'h0) && (gap == 3'h7);
      if (go)
        left <= n_chars;
      else if ((left != 4'h0) && (gap == 3'h7))
        left <= left - 4'h1;
    end
  end

  always_ff @(posedge aclk)
    data_read <= aresetn && pop;

  assign receive_idle_flag = (left == 4'h0);
endmodule

// File: tb/baud_gen_tb.sv
`timescale 1ns/100ps
module baud_gen_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic char_done, data_read, receive_idle_flag;
  logic timer_tick, baud_tick, overrun_error_flag, irq;
  logic [3:0] n_chars = 4'h0;
  logic go = 1'b0;
  logic pop = 1'b0;
  int errors = 0;
  int n_compared = 0;

  baud_gen i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .char_done, .data_read, .receive_idle_flag, .timer_tick, .baud_tick,
    .overrun_error_flag, .irq);

  serial_partner i_partner (.aclk, .aresetn, .n_chars, .go, .pop, .char_done,
    .data_read, .receive_idle_flag);

  initial forever #20 aclk = ~aclk;

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end while (!s_axi_bvalid && k < 100);
    check("bvalid", 32'(s_axi_bvalid), 32'h1);
    check("bresp", 32'(s_axi_bresp), 32'(resp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input logic [1:0] resp);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end while (!s_axi_rvalid && k < 100);
    check("rvalid", 32'(s_axi_rvalid), 32'h1);
    check("rresp", 32'(s_axi_rresp), 32'(resp));
    check("rdata", s_axi_rdata, exp);
  endtask

  // Cycles from one sampled pulse to the next; a hang ends at the bound
  task automatic gap(input bit use_baud, output int c);
    int k;
    k = 0;
    c = 0;
    do
      @(posedge aclk);
    while (!(use_baud ? baud_tick : timer_tick) && ++k < 9000);
    do
    begin
      @(posedge aclk);
      c++;
    end while (!(use_baud ? baud_tick : timer_tick) && c < 9000);
  endtask

  function automatic int mult(input logic [2:0] c);
    if (c[baud_pkg::CTRL_SYNC_BIT]) return 4;
    if (c[baud_pkg::CTRL_WIDE_BIT]) return c[baud_pkg::CTRL_HS_BIT] ? 4 : 16;
    return c[baud_pkg::CTRL_HS_BIT] ? 16 : 64;
  endfunction

  task automatic send(input logic [3:0] n);
    int k;
    k = 0;
    n_chars <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (!receive_idle_flag && ++k < 200);
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_reset;
    int p;
    rd(baud_pkg::ADDR_CTRL, 32'h0, baud_pkg::RESP_OKAY);
    rd(baud_pkg::ADDR_DIV_HIGH, 32'h0, baud_pkg::RESP_OKAY);
    rd(baud_pkg::ADDR_STATUS, 32'h1, baud_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, baud_pkg::RESP_SLVERR);
    wr(baud_pkg::ADDR_TIMER, 32'h5, baud_pkg::RESP_SLVERR);
    // Lane 0 strobe low: the write is answered but must not land
    s_axi_wstrb <= 4'he;
    wr(baud_pkg::ADDR_CTRL, 32'h1, baud_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(baud_pkg::ADDR_CTRL, 32'h0, baud_pkg::RESP_OKAY);
    // A high byte alone must not stretch the period while still narrow
    wr(baud_pkg::ADDR_DIV_HIGH, 32'h1, baud_pkg::RESP_OKAY);
    gap(1'b0, p);
    check("timer period", 32'(p), 32'h1);
    gap(1'b1, p);
    check("baud period", 32'(p), 32'd64);
  endtask

  task automatic t_modes;
    int p;
    int n;
    logic [2:0] c;
    for (int m = 0; m < 8; m++)
    begin
      c = 3'(m);
      n = c[baud_pkg::CTRL_WIDE_BIT] ? 32'h102 : 32'h2;
      wr(baud_pkg::ADDR_CTRL, 32'(c), baud_pkg::RESP_OKAY);
      wr(baud_pkg::ADDR_DIV_HIGH, 32'h1, baud_pkg::RESP_OKAY);
      wr(baud_pkg::ADDR_DIV_LOW, 32'h2, baud_pkg::RESP_OKAY);
      gap(1'b0, p);
      check("timer period", 32'(p), 32'(n + 1));
      // Measured twice so the steady third tick is reached as well
      repeat (2)
      begin
        gap(1'b1, p);
        check("baud period", 32'(p), 32'(mult(c) * (n + 1)));
      end
    end
  endtask

  // Mid-count divisor write must not wait for the old period
  task automatic t_clear;
    int p;
    wr(baud_pkg::ADDR_CTRL, 32'h1, baud_pkg::RESP_OKAY);
    wr(baud_pkg::ADDR_DIV_HIGH, 32'h10, baud_pkg::RESP_OKAY);
    repeat (50) @(posedge aclk);
    wr(baud_pkg::ADDR_DIV_LOW, 32'h3, baud_pkg::RESP_OKAY);
    @(posedge aclk);
    check("tick after write", 32'(timer_tick), 32'h1);
    gap(1'b0, p);
    check("timer period", 32'(p), 32'h1004);
  endtask

  task automatic t_overrun;
    wr(baud_pkg::ADDR_CTRL, 32'h8, baud_pkg::RESP_OKAY);
    wr(baud_pkg::ADDR_IRQ_ENABLE, 32'h1, baud_pkg::RESP_OKAY);
    send(4'h2);
    rd(baud_pkg::ADDR_STATUS, 32'h9, baud_pkg::RESP_OKAY);
    pop <= 1'b1;
    @(posedge aclk);
    pop <= 1'b0;
    send(4'h2);
    check("overrun", 32'(overrun_error_flag), 32'h1);
    check("irq", 32'(irq), 32'h1);
    rd(baud_pkg::ADDR_IRQ_STATUS, 32'h3, baud_pkg::RESP_OKAY);
    wr(baud_pkg::ADDR_IRQ_ENABLE, 32'h0, baud_pkg::RESP_OKAY);
    @(posedge aclk);
    check("irq masked", 32'(irq), 32'h0);
    wr(baud_pkg::ADDR_IRQ_CLEAR, 32'h3, baud_pkg::RESP_OKAY);
    wr(baud_pkg::ADDR_IRQ_ENABLE, 32'h3, baud_pkg::RESP_OKAY);
    @(posedge aclk);
    check("irq cleared", 32'(irq), 32'h0);
    wr(baud_pkg::ADDR_CTRL, 32'h0, baud_pkg::RESP_OKAY);
    @(posedge aclk);
    check("overrun off", 32'(overrun_error_flag), 32'h0);
  endtask

  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Longest scenario spends up to some sixteen thousand cycles in one mode
  initial
  begin
    #(40 * 100000);
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_clear();
    t_overrun();
    stop_test();
  end
endmodule
